// File: hitb_bridge.sv
// Purpose: Host two-wire slave with tuner transaction registers
// Assumes: Host bus sampled by the 50 MHz clock; no clock stretching
// Notes:   The tuner engine runs alone once launched
//
// Contract
// - Host read: subaddress write, then separate read
// - Slave address 101110, select bit, direction
// - Read phase: ack, send bytes while acked
// - Subaddress selects first of consecutive registers
// - Tuner master at 100 or 400 kbit/s
// - Tuner master is sole master, no arbitration
// - Host stages transaction, device runs it alone
// - Target register: address 7:1, direction bit 0
// - Eight data registers, lowest sent first
// - Control: count 7:5, rate 0, go 2
// - Outcome in status bits 1:0 and pin
// - Error flag set on failed transaction
// - Done flag only on normal completion
// - Interrupt pin gated by mask register
// - Raw, masked, mask and clear registers
// - Tuner write: start, address, data, stop
// - Tuner read: subaddress, stop, restart, nack last
// - Received bytes land from lowest data register
// - Select pin taken at reset release
`timescale 1ns/100ps
`default_nettype none
module hitb_bridge #(
	parameter int NUM_DATA = 8
) (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rstn_i,
	// Host two-wire port
	input  wire logic host_scl_i,
	output logic      host_scl_o,
	output logic      host_scl_oe_o,
	input  wire logic host_sda_i,
	output logic      host_sda_o,
	output logic      host_sda_oe_o,
	input  wire logic slave_addr_select_pin_i,
	output logic      host_irq_out_o,
	// Tuner two-wire port
	input  wire logic tuner_bus_clock_line_i,
	output logic      tuner_bus_clock_line_o,
	output logic      tuner_bus_clock_line_oe_o,
	input  wire logic tuner_bus_data_line_i,
	output logic      tuner_bus_data_line_o,
	output logic      tuner_bus_data_line_oe_o
);

	typedef enum logic [2:0] {
		H_IDLE, H_ADDR, H_AACK, H_RX, H_RACK, H_TX, H_TACK
	} hitb_hs_st_t;

	hitb_hs_st_t hst_r;
	logic [3:0]  hbc_r;
	logic [7:0]  hsh_r, ptr_r, rd_byte;
	logic        rw_r, sub_r, hsda_low_r;
	logic        hscl_q1, hscl_q2, hscl_q3;
	logic        hsda_q1, hsda_q2, hsda_q3;
	logic        sel_q1, sel_q2, sel_r;
	logic [1:0]  sel_cnt_r;
	logic        scl_rise, scl_fall, start_c, stop_c;

	logic [7:0]  tgt_r;
	logic [7:0]  data_r [NUM_DATA];
	logic [2:0]  cnt_r;
	logic        rate_r, busy_r, irq_r;
	logic [1:0]  mask_r, raw_r, clr, set;
	logic        wr_en;
	logic        go;
	logic        go_r;
	logic [2:0]  tm_idx;
	logic        tm_we, tm_done, tm_err;
	logic [7:0]  tm_rx;

	////////////////////////////////////////////////////////////////////
	function automatic logic in_data(input logic [7:0] a);
		in_data = (a >= hitb_pkg::OFS_DATA0) && (a <= hitb_pkg::OFS_DATA7);
	endfunction

	function automatic logic [2:0] data_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - hitb_pkg::OFS_DATA0;
		data_idx = d[2:0];
	endfunction

	////////////////////////////////////////////////////////////////////
	// Host pins are asynchronous; data uses the second stage, edges compare the second and third
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{hscl_q1, hscl_q2, hscl_q3} <= 3'h7;
			{hsda_q1, hsda_q2, hsda_q3} <= 3'h7;
			{sel_q1, sel_q2} <= 2'h0;
		end else begin
			hscl_q1 <= host_scl_i;
			hscl_q2 <= hscl_q1;
			hscl_q3 <= hscl_q2;
			hsda_q1 <= host_sda_i;
			hsda_q2 <= hsda_q1;
			hsda_q3 <= hsda_q2;
			sel_q1 <= slave_addr_select_pin_i;
			sel_q2 <= sel_q1;
		end
	end

	assign scl_rise = hscl_q2 & ~hscl_q3;
	assign scl_fall = ~hscl_q2 & hscl_q3;
	assign start_c  = hscl_q2 & hscl_q3 & ~hsda_q2 & hsda_q3;
	assign stop_c   = hscl_q2 & hscl_q3 & hsda_q2 & ~hsda_q3;

	// Select level is held from just after reset until the next one
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sel_cnt_r <= 2'h0;
			sel_r <= 1'b0;
		end else if (sel_cnt_r != hitb_pkg::SEL_WAIT) begin
			sel_cnt_r <= sel_cnt_r + 2'h1;
			sel_r <= sel_q2;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Host slave: a write carries subaddress then data, a read streams
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hst_r <= H_IDLE;
			hbc_r <= 4'h0;
			hsh_r <= 8'h00;
			ptr_r <= 8'h00;
			{rw_r, sub_r, hsda_low_r} <= 3'h0;
		end else if (start_c) begin
			hst_r <= H_ADDR;
			hbc_r <= 4'h0;
			hsda_low_r <= 1'b0;
		end else if (stop_c) begin
			hst_r <= H_IDLE;
			hsda_low_r <= 1'b0;
		end else begin
			case (hst_r)
			H_ADDR, H_RX: begin
				if (scl_rise && hbc_r != 4'h8) begin
					hsh_r <= {hsh_r[6:0], hsda_q2};
					hbc_r <= hbc_r + 4'h1;
				end
				if (scl_fall && hbc_r == 4'h8) begin
					hbc_r <= 4'h0;
					if (hst_r == H_RX) begin
						hst_r <= H_RACK;
						hsda_low_r <= 1'b1;
						sub_r <= 1'b0;
						ptr_r <= sub_r ? hsh_r : ptr_r + 8'h01;
					end else if (hsh_r[7:1] == {hitb_pkg::HOST_ADDR_HI, sel_r}) begin
						hst_r <= H_AACK;
						hsda_low_r <= 1'b1;
						rw_r <= hsh_r[0];
						sub_r <= ~hsh_r[0];
					end else begin
						hst_r <= H_IDLE;
					end
				end
			end
			H_RACK: if (scl_fall) begin
				hst_r <= H_RX;
				hsda_low_r <= 1'b0;
			end
			H_AACK, H_TACK: begin
				if (hst_r == H_TACK && scl_rise && hsda_q2) begin
					hst_r <= H_IDLE;
				end else if (scl_fall) begin
					hbc_r <= 4'h0;
					if (rw_r || hst_r == H_TACK) begin
						hst_r <= H_TX;
						hsh_r <= rd_byte;
						hsda_low_r <= ~rd_byte[7];
						ptr_r <= ptr_r + 8'h01;
					end else begin
						hst_r <= H_RX;
						hsda_low_r <= 1'b0;
					end
				end
			end
			H_TX: if (scl_fall) begin
				hbc_r <= hbc_r + 4'h1;
				if (hbc_r == 4'h7) begin
					hst_r <= H_TACK;
					hsda_low_r <= 1'b0;
				end else begin
					hsh_r <= {hsh_r[6:0], 1'b0};
					hsda_low_r <= ~hsh_r[6];
				end
			end
			default: hsda_low_r <= 1'b0;
			endcase
		end
	end

	assign wr_en = (hst_r == H_RX) && scl_fall && (hbc_r == 4'h8) && !sub_r;

	////////////////////////////////////////////////////////////////////
	// Register read decode; reserved bits read zero
	always_comb begin
		rd_byte = 8'h00;
		if (in_data(ptr_r))
			rd_byte = data_r[data_idx(ptr_r)];
		else
			case (ptr_r)
			hitb_pkg::OFS_TGT:  rd_byte = tgt_r;
			hitb_pkg::OFS_CTRL: rd_byte = {cnt_r, 2'h0, busy_r, 1'b0, rate_r};
			hitb_pkg::OFS_RAW:  rd_byte = {6'h00, raw_r};
			hitb_pkg::OFS_STAT: rd_byte = {6'h00, raw_r & mask_r};
			hitb_pkg::OFS_MASK: rd_byte = {6'h00, mask_r};
			default:            rd_byte = 8'h00;
			endcase
	end

	////////////////////////////////////////////////////////////////////
	// Staging registers written by the host
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tgt_r <= hitb_pkg::RST_BYTE;
			cnt_r <= hitb_pkg::RST_CNT;
			rate_r <= 1'b0;
			mask_r <= hitb_pkg::RST_IRQ;
		end else if (wr_en) begin
			if (ptr_r == hitb_pkg::OFS_TGT)
				tgt_r <= hsh_r;
			if (ptr_r == hitb_pkg::OFS_CTRL) begin
				cnt_r <= hsh_r[hitb_pkg::CTRL_CNT_LSB +: 3];
				rate_r <= hsh_r[hitb_pkg::CTRL_RATE_BIT];
			end
			if (ptr_r == hitb_pkg::OFS_MASK)
				mask_r <= hsh_r[1:0];
		end
	end

	// Tuner results overwrite host data while a read runs
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < NUM_DATA; i++)
				data_r[i] <= hitb_pkg::RST_BYTE;
		end else if (tm_we) begin
			data_r[tm_idx] <= tm_rx;
		end else if (wr_en && in_data(ptr_r)) begin
			data_r[data_idx(ptr_r)] <= hsh_r;
		end
	end

	// Go only launches from idle; it reads back as busy
	assign go = wr_en && (ptr_r == hitb_pkg::OFS_CTRL) &&
		hsh_r[hitb_pkg::CTRL_GO_BIT] && !busy_r;

	// Launch a clock late so the engine takes the count and rate just written
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			go_r <= 1'b0;
		else
			go_r <= go;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			busy_r <= 1'b0;
		else if (go)
			busy_r <= 1'b1;
		else if (tm_done || tm_err)
			busy_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// Sticky flags: a new event beats a clear in the same cycle
	assign clr = (wr_en && ptr_r == hitb_pkg::OFS_CLR) ? hsh_r[1:0] : 2'h0;
	assign set = {tm_err, tm_done};

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			raw_r <= hitb_pkg::RST_IRQ;
			irq_r <= 1'b0;
		end else begin
			raw_r <= (raw_r & ~clr) | set;
			irq_r <= |(raw_r & mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////
	hitb_tuner_master u_tm (
		.ref_clk_i                 (ref_clk_i),
		.rstn_i                    (rstn_i),
		.start_i                   (go_r),
		.rate_fast_i               (rate_r),
		.tgt_addr_i                (tgt_r),
		.count_i                   (cnt_r),
		.tx_byte_i                 (data_r[tm_idx]),
		.byte_idx_o                (tm_idx),
		.rx_we_o                   (tm_we),
		.rx_data_o                 (tm_rx),
		.done_o                    (tm_done),
		.err_o                     (tm_err),
		.tuner_bus_clock_line_i    (tuner_bus_clock_line_i),
		.tuner_bus_clock_line_o    (tuner_bus_clock_line_o),
		.tuner_bus_clock_line_oe_o (tuner_bus_clock_line_oe_o),
		.tuner_bus_data_line_i     (tuner_bus_data_line_i),
		.tuner_bus_data_line_o     (tuner_bus_data_line_o),
		.tuner_bus_data_line_oe_o  (tuner_bus_data_line_oe_o)
	);

	// Host clock is never stretched
	assign host_scl_o     = 1'b0;
	assign host_scl_oe_o  = 1'b0;
	assign host_sda_o     = 1'b0;
	assign host_sda_oe_o  = hsda_low_r;
	assign host_irq_out_o = irq_r;

endmodule // hitb_bridge
`default_nettype wire

// File: hitb_bridge_monitor.sv
// Purpose: Port-level temporal checks of the host-to-tuner bridge
// Assumes: Bound to the top module; sees its ports only
// Notes:   One clock domain, so default clocking and disable are used
`timescale 1ns/100ps
`default_nettype none
module hitb_bridge_monitor (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Host side
	input wire logic host_scl_i,
	input wire logic host_scl_o,
	input wire logic host_scl_oe_o,
	input wire logic host_sda_o,
	input wire logic host_sda_oe_o,
	input wire logic host_irq_out_o,
	// Tuner side
	input wire logic tuner_bus_clock_line_o,
	input wire logic tuner_bus_clock_line_oe_o,
	input wire logic tuner_bus_data_line_o,
	input wire logic tuner_bus_data_line_oe_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	////////////////////////////////////////////////////////////////////////
	a_host_no_stretch: assert property (!host_scl_oe_o)
		else $error("host clock line pulled by slave");
	a_open_drain_low: assert property (!host_scl_o && !host_sda_o
		&& !tuner_bus_clock_line_o && !tuner_bus_data_line_o)
		else $error("open-drain line driven high");
	// Host data may only move while host SCL is low
	a_host_sda_move: assert property ($changed(host_sda_oe_o)
		|-> !host_scl_i && !$past(host_scl_i))
		else $error("host data changed with clock high");
	a_tuner_high_min: assert property ($fell(tuner_bus_clock_line_oe_o)
		|=> !tuner_bus_clock_line_oe_o [*8])
		else $error("tuner clock high phase too short");
	a_tuner_low_min: assert property ($rose(tuner_bus_clock_line_oe_o)
		|=> tuner_bus_clock_line_oe_o [*8])
		else $error("tuner clock low phase too short");
	// Start and stop edges sit well inside a released clock phase
	a_start_stop_mid: assert property ($changed(tuner_bus_data_line_oe_o)
		&& !tuner_bus_clock_line_oe_o |-> !$past(tuner_bus_clock_line_oe_o, 8))
		else $error("tuner data edge too close to clock edge");
	a_irq_bus_idle: assert property ($rose(host_irq_out_o)
		|-> !tuner_bus_clock_line_oe_o && !tuner_bus_data_line_oe_o)
		else $error("interrupt raised while tuner bus busy");
	a_irq_level_hold: assert property ($rose(host_irq_out_o)
		|=> host_irq_out_o [*2])
		else $error("interrupt request not held");
	c_irq: cover property ($rose(host_irq_out_o));
	c_tuner_stop: cover property ($fell(tuner_bus_data_line_oe_o)
		&& !tuner_bus_clock_line_oe_o);
	c_host_ack: cover property ($rose(host_sda_oe_o));
endmodule // hitb_bridge_monitor
`default_nettype wire

// File: hitb_bridge_tb_top.sv
// Purpose: Self-checking bench of the host-to-tuner bridge
// Assumes: Bench acts as host master; tuner model on the far bus
// Notes:   Host SCL is high 8 clocks and low 10 per bit, the shortest the slave takes
`timescale 1ns/100ps
`default_nettype none
module hitb_bridge_tb_top;
	logic       ref_clk;
	logic       rstn;
	logic       scl_drv;
	logic       sda_low;
	logic       sel;
	logic       nack;
	logic       slow;
	logic [7:0] dadr;
	logic [7:0] wbuf [8];
	logic [7:0] rbuf [8];
	int         num_errors;
	int         n_tests;
	int         lo_n;
	int         lo_last;
	logic       h_scl_o, h_scl_oe, h_sda_o, h_sda_oe, irq;
	logic       t_c_o, t_c_oe, t_d_o, t_d_oe, m_c_oe, m_d_oe;
	logic [7:0] m_last;
	logic [3:0] m_nwr, m_nrd;
	wire logic  host_scl = scl_drv & ~h_scl_oe;
	wire logic  host_sda = ~(sda_low | h_sda_oe);
	wire logic  t_scl    = ~(t_c_oe | m_c_oe);
	wire logic  t_sda    = ~(t_d_oe | m_d_oe);
	// Address, write data, expected read-back
	localparam logic [23:0] ROWS [9] = '{24'h55a5a5, 24'h561111,
		24'h5d8888, 24'hfdff03, 24'hf9ff00, 24'hfbff00, 24'hffff00,
		24'h30ff00, 24'h5ee1e1};
	// Expected tuner clock low phase: one half period plus the reload clock
	localparam logic [7:0] LO_FAST = 8'(hitb_pkg::HALF_FAST_CYC + 9'h001);
	localparam logic [7:0] LO_STD  = 8'(hitb_pkg::HALF_STD_CYC + 9'h001);
	hitb_bridge #(.NUM_DATA(8)) dut (.ref_clk_i(ref_clk), .rstn_i(rstn),
		.host_scl_i(host_scl), .host_scl_o(h_scl_o),
		.host_scl_oe_o(h_scl_oe), .host_sda_i(host_sda),
		.host_sda_o(h_sda_o), .host_sda_oe_o(h_sda_oe),
		.slave_addr_select_pin_i(sel), .host_irq_out_o(irq),
		.tuner_bus_clock_line_i(t_scl), .tuner_bus_clock_line_o(t_c_o),
		.tuner_bus_clock_line_oe_o(t_c_oe), .tuner_bus_data_line_i(t_sda),
		.tuner_bus_data_line_o(t_d_o), .tuner_bus_data_line_oe_o(t_d_oe));
	hitb_tuner_model u_tuner (.scl_i(t_scl), .sda_i(t_sda), .nack_i(nack),
		.slow_i(slow), .scl_oe_o(m_c_oe), .sda_oe_o(m_d_oe),
		.last_o(m_last), .nwr_o(m_nwr), .nrd_o(m_nrd));
	initial begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Length of the last tuner clock low phase, in clocks
	always @(posedge ref_clk) begin
		lo_n <= t_c_oe ? lo_n + 1 : 0;
		if (!t_c_oe && lo_n != 0)
			lo_last <= lo_n;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic chk_byte(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		chk_byte(nm, {7'h0, e}, {7'h0, g});
	endtask
	// Data moves two clocks after SCL falls so it never looks like a start
	task automatic hbit(input logic b, output logic r);
		cyc(2);
		sda_low = !b;
		cyc(8);
		scl_drv = 1;
		cyc(4);
		r = host_sda;
		cyc(4);
		scl_drv = 0;
	endtask
	task automatic hbyte(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic ak);
		for (int i = 7; i >= 0; i--) hbit(d[i], q[i]);
		hbit(a, ak);
	endtask
	task automatic hstart;
		sda_low = 0;
		scl_drv = 1;
		cyc(8);
		sda_low = 1;
		cyc(8);
		scl_drv = 0;
	endtask
	task automatic hstop;
		cyc(2);
		sda_low = 1;
		cyc(8);
		scl_drv = 1;
		cyc(8);
		sda_low = 0;
		cyc(8);
	endtask
	task automatic probe(input logic [7:0] a, input logic e);
		logic [7:0] q;
		logic       k;
		hstart();
		hbyte(a, 1, q, k);
		chk_bit("address ack", e, k);
		hstop();
	endtask
	task automatic hwr(input logic [7:0] a, input int n);
		logic [7:0] q;
		logic       k;
		hstart();
		hbyte(dadr, 1, q, k);
		chk_bit("write ack", 1'b0, k);
		hbyte(a, 1, q, k);
		for (int i = 0; i < n; i++) hbyte(wbuf[i], 1, q, k);
		hstop();
	endtask
	task automatic wr1(input logic [7:0] a, input logic [7:0] d);
		wbuf[0] = d;
		hwr(a, 1);
	endtask
	task automatic hrd(input logic [7:0] a, input int n);
		logic [7:0] q;
		logic       k;
		hstart();
		hbyte(dadr, 1, q, k);
		hbyte(a, 1, q, k);
		hstop();
		hstart();
		hbyte(dadr | 8'h01, 1, q, k);
		chk_bit("read ack", 1'b0, k);
		for (int i = 0; i < n; i++) hbyte(8'hff, i == n - 1, rbuf[i], k);
		hstop();
	endtask
	task automatic reg_is(input logic [7:0] a, input logic [7:0] e);
		hrd(a, 1);
		chk_byte("register", e, rbuf[0]);
	endtask
	// Polls busy instead of relying on the interrupt pin
	task automatic wait_idle;
		int i;
		i = 0;
		rbuf[0] = 8'h04;
		while (rbuf[0][2] !== 1'b0 && i < 80) begin
			hrd(8'h5e, 1);
			i++;
		end
		chk_bit("busy", 1'b0, rbuf[0][2]);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rstn, sda_low, sel, nack, slow} = '0;
		scl_drv = 1;
		num_errors = 0;
		n_tests = 0;
		dadr = 8'hb8;
		cyc(5);
		rstn = 1;
		cyc(8);
		foreach (ROWS[i]) begin
			wr1(ROWS[i][23:16], ROWS[i][15:8]);
			reg_is(ROWS[i][23:16], ROWS[i][7:0]);
		end
		wbuf[0] = 8'h3c;
		wbuf[1] = 8'hc3;
		wbuf[2] = 8'h5a;
		hwr(8'h56, 3);
		hrd(8'h56, 3);
		for (int i = 0; i < 3; i++) chk_byte("burst", wbuf[i], rbuf[i]);
		probe(8'hba, 1'b1);
		// Fast tuner write of two staged bytes
		wr1(8'h55, {7'h61, 1'b0});
		wr1(8'hfd, 8'h01);
		wr1(8'h5e, 8'h45);
		wr1(8'h5e, 8'h45);
		reg_is(8'h5e, 8'h45);
		wait_idle();
		reg_is(8'h5e, 8'h41);
		chk_byte("tuner low fast", LO_FAST, 8'(lo_last));
		chk_byte("tuner writes", 8'h02, {4'h0, m_nwr});
		chk_byte("tuner last", 8'hc3, m_last);
		reg_is(8'hf9, 8'h01);
		reg_is(8'hfb, 8'h01);
		chk_bit("irq", 1'b1, irq);
		wr1(8'hfd, 8'h00);
		chk_bit("irq", 1'b0, irq);
		reg_is(8'hfb, 8'h00);
		wr1(8'hff, 8'h03);
		reg_is(8'hf9, 8'h00);
		// Standard-rate read from a stretching tuner
		slow = 1;
		wr1(8'h55, {7'h61, 1'b1});
		wr1(8'h56, 8'h07);
		wr1(8'h5e, 8'h44);
		wait_idle();
		chk_byte("tuner low std", LO_STD, 8'(lo_last));
		hrd(8'h56, 2);
		chk_byte("rx 1", 8'h90, rbuf[0]);
		chk_byte("rx 2", 8'h91, rbuf[1]);
		chk_byte("tuner sub", 8'h07, m_last);
		chk_byte("tuner reads", 8'h02, {4'h0, m_nrd});
		reg_is(8'hf9, 8'h01);
		wr1(8'hff, 8'h03);
		// Tuner refuses the data byte
		{slow, nack} = 2'b01;
		wr1(8'h55, {7'h61, 1'b0});
		wr1(8'h5e, 8'h25);
		wait_idle();
		reg_is(8'hf9, 8'h02);
		wr1(8'hfd, 8'h02);
		chk_bit("irq", 1'b1, irq);
		wr1(8'hfd, 8'h01);
		chk_bit("irq", 1'b0, irq);
		nack = 0;
		// Second reset with the select strap high
		rstn = 0;
		sel = 1;
		cyc(5);
		rstn = 1;
		cyc(8);
		sel = 0;
		dadr = 8'hba;
		reg_is(8'h55, 8'h00);
		probe(8'hb8, 1'b1);
		complete_run();
	end
	initial begin
		#1_800_000;
		num_errors++;
		complete_run();
	end
endmodule // hitb_bridge_tb_top
bind hitb_bridge hitb_bridge_monitor u_mon (.ref_clk_i(ref_clk_i),
	.rstn_i(rstn_i), .host_scl_i(host_scl_i), .host_scl_o(host_scl_o),
	.host_scl_oe_o(host_scl_oe_o), .host_sda_o(host_sda_o),
	.host_sda_oe_o(host_sda_oe_o), .host_irq_out_o(host_irq_out_o),
	.tuner_bus_clock_line_o(tuner_bus_clock_line_o),
	.tuner_bus_clock_line_oe_o(tuner_bus_clock_line_oe_o),
	.tuner_bus_data_line_o(tuner_bus_data_line_o),
	.tuner_bus_data_line_oe_o(tuner_bus_data_line_oe_o));
`default_nettype wire

// File: hitb_pkg.sv
// Purpose: Shared constants of the host-to-tuner two-wire bridge
// Assumes: 50 MHz reference clock, 8-bit register space
// Notes:   Offsets, field positions, reset values and bit timing
package hitb_pkg;

	// Clock and tuner bus rates
	localparam int CLK_HZ       = 50_000_000;
	localparam int RATE_STD_HZ  = 100_000;
	localparam int RATE_FAST_HZ = 400_000;
	// Half bit periods round up so the bus never runs above its rate
	localparam logic [8:0] HALF_STD_CYC =
		9'((CLK_HZ + 2 * RATE_STD_HZ - 1) / (2 * RATE_STD_HZ));
	localparam logic [8:0] HALF_FAST_CYC =
		9'((CLK_HZ + 2 * RATE_FAST_HZ - 1) / (2 * RATE_FAST_HZ));

	// Host slave address: upper six bits, then the select bit
	localparam logic [5:0] HOST_ADDR_HI = 6'h2e;

	// Register offsets
	localparam logic [7:0] OFS_TGT   = 8'h55;
	localparam logic [7:0] OFS_DATA0 = 8'h56;
	localparam logic [7:0] OFS_DATA7 = 8'h5d;
	localparam logic [7:0] OFS_CTRL  = 8'h5e;
	localparam logic [7:0] OFS_RAW   = 8'hf9;
	localparam logic [7:0] OFS_STAT  = 8'hfb;
	localparam logic [7:0] OFS_MASK  = 8'hfd;
	localparam logic [7:0] OFS_CLR   = 8'hff;

	// Field positions
	localparam int CTRL_RATE_BIT = 0;
	localparam int CTRL_GO_BIT   = 2;
	localparam int CTRL_CNT_LSB  = 5;
	localparam int IRQ_DONE_BIT  = 0;
	localparam int IRQ_ERR_BIT   = 1;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] RST_CNT  = 3'h0;
	localparam logic [1:0] RST_IRQ  = 2'h0;

	// Clocks after reset release before the select pin is taken
	localparam logic [1:0] SEL_WAIT = 2'h3;

endpackage

// File: hitb_tuner_master.sv
// Purpose: Single-master two-wire engine toward the tuner
// Assumes: Sole master on its bus; slave may stretch the clock
// Notes:   A read sends data byte 0 as subaddress, stops, restarts
`timescale 1ns/100ps
`default_nettype none
module hitb_tuner_master (
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rstn_i,
	// Transaction control
	input  wire logic       start_i,
	input  wire logic       rate_fast_i,
	input  wire logic [7:0] tgt_addr_i,
	input  wire logic [2:0] count_i,
	input  wire logic [7:0] tx_byte_i,
	output logic      [2:0] byte_idx_o,
	output logic            rx_we_o,
	output logic      [7:0] rx_data_o,
	output logic            done_o,
	output logic            err_o,
	// Tuner bus pins
	input  wire logic       tuner_bus_clock_line_i,
	output logic            tuner_bus_clock_line_o,
	output logic            tuner_bus_clock_line_oe_o,
	input  wire logic       tuner_bus_data_line_i,
	output logic            tuner_bus_data_line_o,
	output logic            tuner_bus_data_line_oe_o
);

	typedef enum logic [1:0] {T_IDLE, T_START, T_BIT, T_STOP} hitb_tm_st_t;

	hitb_tm_st_t st_r;
	logic [1:0]  ph_r;
	logic [8:0]  tmr_r;
	logic [3:0]  bc_r, idx_r, n_r;
	logic [7:0]  sh_r, ad_r;
	logic        rx_r, hdr_r, rdph_r, again_r, fail_r, fast_r;
	logic        scl_low_r, sda_low_r, done_r, errp_r, rx_we_r;
	logic        scl_q1, scl_q2, sda_q1, sda_q2;
	logic        stretch, tick;
	logic [8:0]  half;

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{scl_q1, scl_q2, sda_q1, sda_q2} <= 4'hf;
		end else begin
			scl_q1 <= tuner_bus_clock_line_i;
			scl_q2 <= scl_q1;
			sda_q1 <= tuner_bus_data_line_i;
			sda_q2 <= sda_q1;
		end
	end

	// A released clock held low by the slave freezes the timer
	assign stretch = ~scl_low_r & ~scl_q2;
	assign tick    = (tmr_r == 9'h000) & ~stretch;
	assign half    = fast_r ? hitb_pkg::HALF_FAST_CYC : hitb_pkg::HALF_STD_CYC;

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			tmr_r <= hitb_pkg::HALF_STD_CYC;
		else if (st_r == T_IDLE || tick)
			tmr_r <= half;
		else if (!stretch)
			tmr_r <= tmr_r - 9'h001;
	end

	////////////////////////////////////////////////////////////////////
	// No arbitration: the bus is assumed to be ours alone
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= T_IDLE;
			ph_r <= 2'h0;
			bc_r <= 4'h0;
			idx_r <= 4'h0;
			n_r <= 4'h0;
			sh_r <= 8'h00;
			ad_r <= 8'h00;
			{rx_r, hdr_r, rdph_r, again_r, fail_r, fast_r} <= 6'h00;
			{scl_low_r, sda_low_r, done_r, errp_r, rx_we_r} <= 5'h00;
		end else begin
			done_r <= 1'b0;
			errp_r <= 1'b0;
			rx_we_r <= 1'b0;
			if (rx_we_r)
				idx_r <= idx_r + 4'h1;
			case (st_r)
			T_IDLE: if (start_i) begin
				st_r <= T_START;
				ph_r <= 2'h0;
				ad_r <= tgt_addr_i;
				fast_r <= rate_fast_i;
				n_r <= (count_i == 3'h0) ? 4'h8 : {1'b0, count_i};
				{rdph_r, again_r, fail_r} <= 3'h0;
				idx_r <= 4'h0;
			end
			T_START: begin
				if (ph_r == 2'h0) begin
					scl_low_r <= 1'b0;
					sda_low_r <= 1'b0;
					if (tick) begin
						ph_r <= 2'h1;
						sda_low_r <= 1'b1;
					end
				end else if (tick) begin
					scl_low_r <= 1'b1;
					st_r <= T_BIT;
					ph_r <= 2'h0;
					bc_r <= 4'h0;
					{hdr_r, rx_r} <= 2'b10;
					sh_r <= {ad_r[7:1], rdph_r};
				end
			end
			T_BIT: begin
				if (ph_r == 2'h0) begin
					// Ack every read byte but the last
					sda_low_r <= (bc_r != 4'h8) ? (~rx_r & ~sh_r[7]) :
						(rx_r & (idx_r != 4'(n_r - 4'h1)));
					if (tick) begin
						ph_r <= 2'h1;
						scl_low_r <= 1'b0;
					end
				end else if (tick) begin
					scl_low_r <= 1'b1;
					ph_r <= 2'h0;
					if (bc_r != 4'h8) begin
						sh_r <= {sh_r[6:0], sda_q2};
						bc_r <= bc_r + 4'h1;
					end else begin
						bc_r <= 4'h0;
						if (rx_r) begin
							rx_we_r <= 1'b1;
							if (idx_r == 4'(n_r - 4'h1))
								st_r <= T_STOP;
						end else if (sda_q2) begin
							fail_r <= 1'b1;
							st_r <= T_STOP;
						end else if (hdr_r && rdph_r) begin
							{hdr_r, rx_r} <= 2'b01;
						end else if (hdr_r || (!ad_r[0] && idx_r != n_r)) begin
							hdr_r <= 1'b0;
							sh_r <= tx_byte_i;
							idx_r <= idx_r + 4'h1;
						end else begin
							again_r <= ad_r[0];
							idx_r <= 4'h0;
							st_r <= T_STOP;
						end
					end
				end
			end
			T_STOP: begin
				if (ph_r == 2'h0) begin
					sda_low_r <= 1'b1;
					if (tick) begin
						ph_r <= 2'h1;
						scl_low_r <= 1'b0;
					end
				end else if (ph_r == 2'h1) begin
					if (tick) begin
						ph_r <= 2'h2;
						sda_low_r <= 1'b0;
					end
				end else if (tick) begin
					ph_r <= 2'h0;
					if (again_r && !fail_r) begin
						again_r <= 1'b0;
						rdph_r <= 1'b1;
						st_r <= T_START;
					end else begin
						st_r <= T_IDLE;
						done_r <= ~fail_r;
						errp_r <= fail_r;
					end
				end
			end
			default: st_r <= T_IDLE;
			endcase
		end
	end

	assign byte_idx_o = idx_r[2:0];
	assign rx_we_o    = rx_we_r;
	assign rx_data_o  = sh_r;
	assign done_o     = done_r;
	assign err_o      = errp_r;
	assign tuner_bus_clock_line_o    = 1'b0;
	assign tuner_bus_clock_line_oe_o = scl_low_r;
	assign tuner_bus_data_line_o     = 1'b0;
	assign tuner_bus_data_line_oe_o  = sda_low_r;

endmodule // hitb_tuner_master
`default_nettype wire

// File: hitb_tuner_model.sv
// Purpose: Behavioural tuner slave on the isolated two-wire bus
// Assumes: Wires resolved by the bench with pull-ups
// Notes:   Can refuse written bytes and stretch the clock per byte
`timescale 1ns/100ps
`default_nettype none
module hitb_tuner_model #(
	parameter logic [6:0] ADDR  = 7'h61, // Arbitrary slave address
	parameter logic [7:0] RBASE = 8'h90
) (
	// Resolved wires
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	// Behaviour select
	input  wire logic       nack_i,
	input  wire logic       slow_i,
	// Drive and record
	output logic            scl_oe_o,
	output logic            sda_oe_o,
	output logic      [7:0] last_o,
	output logic      [3:0] nwr_o,
	output logic      [3:0] nrd_o
);
	logic [7:0] sh;
	logic [7:0] tx;
	int         bitn;
	logic       act;
	logic       adr;
	logic       rd;
	logic       ok;
	logic       mack;
	initial begin
		{scl_oe_o, sda_oe_o, act, rd, ok} = '0;
		{nwr_o, nrd_o, last_o} = '0;
	end
	always @(negedge sda_i) if (scl_i) begin
		{act, adr, rd} = 3'b110;
		bitn = -1;
	end
	always @(posedge sda_i) if (scl_i) act = 0;
	always @(posedge scl_i) begin
		sh   = {sh[6:0], sda_i};
		mack = !sda_i;
	end
	always @(negedge scl_i) if (act) begin
		if (bitn == 7) begin
			if (adr) begin
				rd = sh[0];
				ok = sh[7:1] == ADDR;
			end else if (!rd) begin
				last_o = sh;
				nwr_o++;
			end
			sda_oe_o = ok && (adr || !rd && !nack_i);
			bitn = 8;
			// Held past the master's own low phase so the stretch is felt
			if (slow_i) begin
				scl_oe_o = 1;
				#8000;
				scl_oe_o = 0;
			end
		end else if (bitn == 8) begin
			bitn = 0;
			tx = 8'hff;
			if (rd && ok && (adr || mack)) begin
				tx = RBASE + 8'(nrd_o);
				nrd_o++;
			end
			adr = 0;
			sda_oe_o = rd && !tx[7];
		end else begin
			bitn++;
			sda_oe_o = rd && !tx[7 - bitn];
		end
	end
endmodule // hitb_tuner_model
`default_nettype wire
